/* File: common/ctb_map.svh */
// Register offsets, field positions and reset values of the card timeout and block registers.
`ifndef CTB_MAP_SVH
`define CTB_MAP_SVH
`define CTB_OFS_TIMEOUT_HI 8'h00
`define CTB_OFS_DATA_TO_LO 8'h04
`define CTB_OFS_BLOCK_LEN 8'h08
`define CTB_OFS_BLOCK_CNT 8'h0C
`define CTB_OFS_BLOCKS_REM 8'h10
`define CTB_OFS_RX_FIRST 8'h14
`define CTB_OFS_RX_SECOND 8'h18
`define CTB_OFS_TX_FIRST 8'h1C
`define CTB_OFS_TX_SECOND 8'h20
`define CTB_OFS_STATUS 8'h24
`define CTB_OFS_MASK 8'h28
`define CTB_OFS_CONTROL 8'h2C
`define CTB_BIT_RESP_TO 4
`define CTB_BIT_READ_TO 3
`define CTB_BIT_RX_FULL 8
`define CTB_BIT_TX_PEND 9
`define CTB_BIT_BIG_ENDIAN 0
`define CTB_BLOCK_SIZE_BYTES_WIDTH 12
`define CTB_RST_REG16 16'h0000
`define CTB_RST_WORD 32'h0000_0000
`define CTB_RESP_OKAY 2'b00
`define CTB_RESP_SLVERR 2'b10
`endif

/* File: common/ctb_pkg.sv */
// Types shared by the card timeout and block register files.
package ctb_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ctb_wr_t;
  typedef enum logic [0:0] {
    CTB_TO_IDLE = 1'b0,
    CTB_TO_RUN = 1'b1
  } ctb_to_state_t;
endpackage

/* File: core/ctb_timeout.sv */
// Wait counter that counts card clock ticks and reports an expired wait.
`timescale 1ns/1ps
module ctb_timeout import ctb_pkg::*; #(
  parameter int W = 8
) (
  // Clock and control.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Wait control.
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_tick,
  input wire logic [W-1:0] i_limit,
  // Result.
  output logic o_expire,
  output logic o_running
);
  ctb_to_state_t state, next_state;
  logic [W-1:0] count, next_count;
  logic expire, next_expire;

  always_comb begin
    next_state = state;
    next_count = count;
    next_expire = 1'b0;
    unique case (state)
      CTB_TO_IDLE: begin
        if (i_start && !i_stop && i_limit != '0) begin
          next_state = CTB_TO_RUN;
          next_count = i_limit;
        end
      end
      CTB_TO_RUN: begin
        if (i_stop) begin
          next_state = CTB_TO_IDLE;
        end else if (i_tick) begin
          if (count == W'(1)) begin
            next_state = CTB_TO_IDLE;
            next_expire = 1'b1;
          end else begin
            next_count = count - W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= CTB_TO_IDLE;
      count <= '0;
      expire <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      count <= next_count;
      expire <= next_expire;
    end
  end

  assign o_expire = expire;
  assign o_running = (state == CTB_TO_RUN);
endmodule

/* File: core/ctb_axil_slave.sv */
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
`include "ctb_map.svh"
module ctb_axil_slave import ctb_pkg::*; (
  // Clock and control.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // AXI4-Lite slave.
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Register side.
  output ctb_wr_t o_wr,
  input wire logic i_wr_err,
  output logic o_rd,
  output logic [7:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_err
);
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic do_wr;

  assign o_s_axi_awready = !aw_held && !bvalid;
  assign o_s_axi_wready = !w_held && !bvalid;
  assign o_s_axi_arready = !rvalid;
  assign do_wr = aw_held && w_held && !bvalid;
  assign o_wr = '{valid: do_wr && i_clk_en, addr: aw_addr, data: w_data, strb: w_strb};
  assign o_rd = i_s_axi_arvalid && !rvalid && i_clk_en;
  assign o_rd_addr = i_s_axi_araddr;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_s_axi_wdata;
      next_w_strb = i_s_axi_wstrb;
    end
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = i_wr_err ? `CTB_RESP_SLVERR : `CTB_RESP_OKAY;
    end else if (bvalid && i_s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (i_s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = i_rd_data;
      next_rresp = i_rd_err ? `CTB_RESP_SLVERR : `CTB_RESP_OKAY;
    end else if (rvalid && i_s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= `CTB_RST_WORD;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `CTB_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= `CTB_RST_WORD;
      rresp <= `CTB_RESP_OKAY;
    end else if (i_clk_en) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign o_s_axi_bvalid = bvalid;
  assign o_s_axi_bresp = bresp;
  assign o_s_axi_rvalid = rvalid;
  assign o_s_axi_rdata = rdata;
  assign o_s_axi_rresp = rresp;
endmodule

/* File: core/ctb_regs.sv */
// Timeout, block size, block count and data word registers of the card host controller.
// What this block does
// RULE1: Response wait of 1-255 card clocks, zero disables.
// RULE2: Missed response sets response timeout status flag.
// RULE3: Response timeout flag interrupts when its enable set.
// RULE4: Data wait count joins upper and lower fields.
// RULE5: Zero data wait disables, else that many clocks.
// RULE6: Late read data sets read timeout flag.
// RULE7: Read timeout flag interrupts when its enable set.
// RULE8: Software may add its own longer timeout.
// RULE9: Software programs block length 1 to 4095.
// RULE10: Block length must match the card setting.
// RULE11: Zero block count runs until stop command.
// RULE12: Nonzero count n moves exactly n blocks.
// RULE13: Blocks remaining down-counter readable at any time.
// RULE14: Received words held in two receive registers.
// RULE15: Received bytes placed in little-endian order.
// RULE16: Transmit data written into two transmit registers.
// RULE17: Transmit byte order follows control endianness bit.
// RULE18: Interrupt only on masked flag rising edge.
// RULE19: Waits start after command or read request, stop on arrival.
// RULE20: Remaining count reloads per command, decrements per block.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ctb_map.svh"
module ctb_regs import ctb_pkg::*; (
  // Clock, reset and enable.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // AXI4-Lite slave.
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Card clock pin.
  input wire logic i_card_clk,
  // Transfer engine events.
  input wire logic i_cmd_sent,
  input wire logic i_resp_start,
  input wire logic i_read_expected,
  input wire logic i_data_start,
  input wire logic i_data_cmd_start,
  input wire logic i_block_done,
  input wire logic i_stop_cmd,
  // Receive bytes from the card.
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  // Transmit bytes to the card.
  output logic [7:0] o_tx_byte,
  output logic o_tx_valid,
  input wire logic i_tx_take,
  // Transfer control and interrupt.
  output logic [11:0] o_block_size_bytes,
  output logic o_xfer_end,
  output logic o_cpu_irq
);
  ctb_wr_t wr;
  logic rd, wr_err, rd_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic card_q1, card_q2, card_q3, tick;
  logic resp_expire, data_expire;
  logic [15:0] timeout_hi, next_timeout_hi, data_to_lo, next_data_to_lo;
  logic [11:0] block_size_bytes, next_block_size_bytes;
  logic [15:0] blocks_to_transfer, next_blocks_to_transfer;
  logic [15:0] blocks_left, next_blocks_left;
  logic [15:0] rx_word_first, next_rx_word_first, rx_word_second, next_rx_word_second;
  logic [15:0] tx_word_first, next_tx_word_first, tx_word_second, next_tx_word_second;
  logic [1:0] rx_idx, next_rx_idx, tx_idx, next_tx_idx;
  logic rx_full, next_rx_full, tx_pend, next_tx_pend;
  logic response_timeout_flag, next_response_timeout_flag;
  logic read_data_timeout_flag, next_read_data_timeout_flag;
  logic response_timeout_irq_enable, next_response_timeout_irq_enable;
  logic read_data_timeout_irq_enable, next_read_data_timeout_irq_enable;
  logic big_endian, next_big_endian;
  logic [7:0] tx_byte, next_tx_byte;
  logic xfer_end, next_xfer_end, irq, next_irq;

  function automatic logic [15:0] merge16(input logic [15:0] old, input ctb_wr_t w);
    merge16 = {w.strb[1] ? w.data[15:8] : old[15:8], w.strb[0] ? w.data[7:0] : old[7:0]};
  endfunction

  function automatic logic hit(input ctb_wr_t w, input logic [7:0] ofs);
    hit = w.valid && (w.addr == ofs);
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] lo, input logic [15:0] hi,
                                           input logic [1:0] idx, input logic big);
    logic [31:0] word;
    logic [1:0] k;
    word = {hi, lo};
    k = big ? (idx ^ 2'b01) : idx;
    pick_byte = word[{k, 3'b000} +: 8];
  endfunction

  ctb_axil_slave u_bus (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_s_axi_awaddr(i_s_axi_awaddr),
    .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb),
    .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr),
    .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp),
    .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready),
    .o_wr(wr),
    .i_wr_err(wr_err),
    .o_rd(rd),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_err(rd_err)
  );

  // The card clock pin is synchronised and its rising edges become ticks.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      card_q1 <= 1'b0;
      card_q2 <= 1'b0;
      card_q3 <= 1'b0;
    end else if (i_clk_en) begin
      card_q1 <= i_card_clk;
      card_q2 <= card_q1;
      card_q3 <= card_q2;
    end
  end
  assign tick = card_q2 && !card_q3;

  ctb_timeout #(.W(8)) u_resp_wait (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_start(i_cmd_sent), // [RULE19]
    .i_stop(i_resp_start), // [RULE19]
    .i_tick(tick),
    .i_limit(timeout_hi[7:0]), // [RULE1]
    .o_expire(resp_expire),
    .o_running()
  );

  ctb_timeout #(.W(24)) u_data_wait (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_start(i_read_expected), // [RULE19]
    .i_stop(i_data_start), // [RULE19]
    .i_tick(tick),
    .i_limit({timeout_hi[15:8], data_to_lo}), // [RULE4] [RULE5]
    .o_expire(data_expire),
    .o_running()
  );

  always_comb begin
    wr_err = 1'b0;
    unique case (wr.addr)
      `CTB_OFS_TIMEOUT_HI, `CTB_OFS_DATA_TO_LO, `CTB_OFS_BLOCK_LEN, `CTB_OFS_BLOCK_CNT,
      `CTB_OFS_BLOCKS_REM, `CTB_OFS_RX_FIRST, `CTB_OFS_RX_SECOND, `CTB_OFS_TX_FIRST,
      `CTB_OFS_TX_SECOND, `CTB_OFS_STATUS, `CTB_OFS_MASK, `CTB_OFS_CONTROL: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    rd_data = `CTB_RST_WORD;
    rd_err = 1'b0;
    unique case (rd_addr)
      `CTB_OFS_TIMEOUT_HI: rd_data = {16'h0000, timeout_hi};
      `CTB_OFS_DATA_TO_LO: rd_data = {16'h0000, data_to_lo};
      `CTB_OFS_BLOCK_LEN: rd_data = {20'h00000, block_size_bytes};
      `CTB_OFS_BLOCK_CNT: rd_data = {16'h0000, blocks_to_transfer};
      `CTB_OFS_BLOCKS_REM: rd_data = {16'h0000, blocks_left}; // [RULE13]
      `CTB_OFS_RX_FIRST: rd_data = {16'h0000, rx_word_first}; // [RULE14]
      `CTB_OFS_RX_SECOND: rd_data = {16'h0000, rx_word_second}; // [RULE14]
      `CTB_OFS_TX_FIRST: rd_data = {16'h0000, tx_word_first};
      `CTB_OFS_TX_SECOND: rd_data = {16'h0000, tx_word_second};
      `CTB_OFS_STATUS: begin
        rd_data[`CTB_BIT_RESP_TO] = response_timeout_flag;
        rd_data[`CTB_BIT_READ_TO] = read_data_timeout_flag;
        rd_data[`CTB_BIT_RX_FULL] = rx_full;
        rd_data[`CTB_BIT_TX_PEND] = tx_pend;
      end
      `CTB_OFS_MASK: begin
        rd_data[`CTB_BIT_RESP_TO] = response_timeout_irq_enable;
        rd_data[`CTB_BIT_READ_TO] = read_data_timeout_irq_enable;
      end
      `CTB_OFS_CONTROL: rd_data[`CTB_BIT_BIG_ENDIAN] = big_endian;
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    next_timeout_hi = hit(wr, `CTB_OFS_TIMEOUT_HI) ? merge16(timeout_hi, wr) : timeout_hi;
    next_data_to_lo = hit(wr, `CTB_OFS_DATA_TO_LO) ? merge16(data_to_lo, wr) : data_to_lo;
    next_block_size_bytes = block_size_bytes;
    if (hit(wr, `CTB_OFS_BLOCK_LEN)) begin
      next_block_size_bytes = 12'(merge16({4'h0, block_size_bytes}, wr));
    end
    next_blocks_to_transfer = hit(wr, `CTB_OFS_BLOCK_CNT) ?
                              merge16(blocks_to_transfer, wr) : blocks_to_transfer;
    next_tx_word_first = hit(wr, `CTB_OFS_TX_FIRST) ?
                         merge16(tx_word_first, wr) : tx_word_first; // [RULE16]
    next_tx_word_second = hit(wr, `CTB_OFS_TX_SECOND) ?
                          merge16(tx_word_second, wr) : tx_word_second; // [RULE16]
    next_response_timeout_irq_enable = response_timeout_irq_enable;
    next_read_data_timeout_irq_enable = read_data_timeout_irq_enable;
    if (hit(wr, `CTB_OFS_MASK) && wr.strb[0]) begin
      next_response_timeout_irq_enable = wr.data[`CTB_BIT_RESP_TO];
      next_read_data_timeout_irq_enable = wr.data[`CTB_BIT_READ_TO];
    end
    next_big_endian = big_endian;
    if (hit(wr, `CTB_OFS_CONTROL) && wr.strb[0]) begin
      next_big_endian = wr.data[`CTB_BIT_BIG_ENDIAN];
    end
    // Status flags clear on a written one; a new event in the same cycle wins.
    next_response_timeout_flag = response_timeout_flag;
    next_read_data_timeout_flag = read_data_timeout_flag;
    if (hit(wr, `CTB_OFS_STATUS) && wr.strb[0]) begin
      next_response_timeout_flag = response_timeout_flag && !wr.data[`CTB_BIT_RESP_TO];
      next_read_data_timeout_flag = read_data_timeout_flag && !wr.data[`CTB_BIT_READ_TO];
    end
    if (resp_expire) begin
      next_response_timeout_flag = 1'b1; // [RULE2]
    end
    if (data_expire) begin
      next_read_data_timeout_flag = 1'b1; // [RULE6]
    end
    next_irq = (next_response_timeout_flag && !response_timeout_flag &&
                response_timeout_irq_enable) || // [RULE3] [RULE18]
               (next_read_data_timeout_flag && !read_data_timeout_flag &&
                read_data_timeout_irq_enable); // [RULE7] [RULE18]
    // Block counting for the current data command.
    next_blocks_left = blocks_left;
    next_xfer_end = 1'b0;
    if (i_data_cmd_start) begin
      next_blocks_left = blocks_to_transfer; // [RULE20]
    end else if (i_block_done && blocks_to_transfer != 16'h0000 && blocks_left != 16'h0000) begin
      next_blocks_left = blocks_left - 16'h0001; // [RULE20]
      next_xfer_end = (blocks_left == 16'h0001); // [RULE12]
    end
    if (i_stop_cmd) begin
      next_xfer_end = 1'b1; // [RULE11]
    end
    // Receive bytes fill the two words, first byte in the low lane.
    next_rx_word_first = rx_word_first;
    next_rx_word_second = rx_word_second;
    next_rx_idx = rx_idx;
    next_rx_full = rx_full;
    if (rd && rd_addr == `CTB_OFS_RX_SECOND) begin
      next_rx_full = 1'b0;
    end
    if (i_rx_valid && !rx_full) begin
      unique case (rx_idx)
        2'b00: next_rx_word_first[7:0] = i_rx_byte; // [RULE15]
        2'b01: next_rx_word_first[15:8] = i_rx_byte; // [RULE15]
        2'b10: next_rx_word_second[7:0] = i_rx_byte; // [RULE15]
        2'b11: next_rx_word_second[15:8] = i_rx_byte; // [RULE15]
      endcase
      next_rx_idx = rx_idx + 2'b01;
      next_rx_full = (rx_idx == 2'b11); // [RULE14]
    end
    // Transmit word goes out once the second register is written.
    next_tx_idx = tx_idx;
    next_tx_pend = tx_pend;
    if (tx_pend && i_tx_take) begin
      next_tx_idx = tx_idx + 2'b01;
      next_tx_pend = (tx_idx != 2'b11);
    end
    if (hit(wr, `CTB_OFS_TX_SECOND)) begin
      next_tx_pend = 1'b1;
      next_tx_idx = 2'b00;
    end
    next_tx_byte = pick_byte(next_tx_word_first, next_tx_word_second, next_tx_idx,
                             next_big_endian); // [RULE17]
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      timeout_hi <= `CTB_RST_REG16;
      data_to_lo <= `CTB_RST_REG16;
      block_size_bytes <= 12'h000;
      blocks_to_transfer <= `CTB_RST_REG16;
      blocks_left <= `CTB_RST_REG16;
      rx_word_first <= `CTB_RST_REG16;
      rx_word_second <= `CTB_RST_REG16;
      tx_word_first <= `CTB_RST_REG16;
      tx_word_second <= `CTB_RST_REG16;
      rx_idx <= 2'b00;
      tx_idx <= 2'b00;
      rx_full <= 1'b0;
      tx_pend <= 1'b0;
      response_timeout_flag <= 1'b0;
      read_data_timeout_flag <= 1'b0;
      response_timeout_irq_enable <= 1'b0;
      read_data_timeout_irq_enable <= 1'b0;
      big_endian <= 1'b0;
      tx_byte <= 8'h00;
      xfer_end <= 1'b0;
      irq <= 1'b0;
    end else if (i_clk_en) begin
      timeout_hi <= next_timeout_hi;
      data_to_lo <= next_data_to_lo;
      block_size_bytes <= next_block_size_bytes;
      blocks_to_transfer <= next_blocks_to_transfer;
      blocks_left <= next_blocks_left;
      rx_word_first <= next_rx_word_first;
      rx_word_second <= next_rx_word_second;
      tx_word_first <= next_tx_word_first;
      tx_word_second <= next_tx_word_second;
      rx_idx <= next_rx_idx;
      tx_idx <= next_tx_idx;
      rx_full <= next_rx_full;
      tx_pend <= next_tx_pend;
      response_timeout_flag <= next_response_timeout_flag;
      read_data_timeout_flag <= next_read_data_timeout_flag;
      response_timeout_irq_enable <= next_response_timeout_irq_enable;
      read_data_timeout_irq_enable <= next_read_data_timeout_irq_enable;
      big_endian <= next_big_endian;
      tx_byte <= next_tx_byte;
      xfer_end <= next_xfer_end;
      irq <= next_irq;
    end
  end

  assign o_rx_ready = !rx_full;
  assign o_tx_valid = tx_pend;
  assign o_tx_byte = tx_byte;
  assign o_block_size_bytes = block_size_bytes;
  assign o_xfer_end = xfer_end;
  assign o_cpu_irq = irq;
endmodule

/* File: testbench/ctb_regs_properties.sv */
// Port checker of the card timeout and block registers.
`timescale 1ns/1ps
module ctb_regs_properties (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register bus.
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic o_s_axi_awready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // Card side.
  input wire logic [7:0] o_tx_byte,
  input wire logic o_tx_valid,
  input wire logic i_tx_take,
  input wire logic i_stop_cmd,
  input wire logic o_xfer_end,
  input wire logic o_cpu_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> $stable(o_s_axi_rdata))
    else $error("read data moved");
  a_read_blocks: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("second read taken");
  a_bresp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write answer dropped");
  a_write_blocks: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("second write taken");
  a_tx_holds: assert property (o_tx_valid && !i_tx_take |=> $stable(o_tx_byte))
    else $error("tx byte moved");
  a_irq_pulse: assert property (o_cpu_irq |=> !o_cpu_irq)
    else $error("irq too long");
  a_end_pulse: assert property (o_xfer_end |=> !o_xfer_end)
    else $error("end too long");
  a_stop_ends: assert property ($rose(i_stop_cmd) |-> ##[1:2] o_xfer_end)
    else $error("stop did not end");
endmodule
bind ctb_regs ctb_regs_properties u_props (.*);

/* File: testbench/ctb_card_model.sv */
// Card side model: gated card clock, byte source and slow byte sink.
`timescale 1ns/1ps
module ctb_card_model (
  // Bench control.
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic i_rx_en,
  // Block handshakes.
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  // Card lines.
  output logic o_card_clk,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_tx_take
);
  logic [7:0] cnt = 8'hA1;
  initial begin
    o_card_clk = 1'b0;
    o_rx_valid = 1'b0;
    o_tx_take = 1'b0;
  end
  always #200 o_card_clk = i_run & ~o_card_clk;
  assign o_rx_byte = o_rx_valid ? cnt : ~cnt;
  always @(posedge i_sys_clk) begin
    if (o_rx_valid && i_rx_ready) begin
      cnt <= cnt + 8'h01;
    end
    o_rx_valid <= i_rx_en || (o_rx_valid && !i_rx_ready);
    o_tx_take <= i_tx_valid && !o_tx_take;
  end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the card timeout and block registers.
`timescale 1ns/1ps
module testbench import ctb_pkg::*; ;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, run = 1'b0, rx_en = 1'b0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, seed = 32'hA4280366;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic [6:0] ev = 7'h00;
  wire logic i_cmd_sent, i_resp_start, i_read_expected, i_data_start;
  wire logic i_data_cmd_start, i_block_done, i_stop_cmd, i_card_clk, i_rx_valid, i_tx_take;
  wire logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire logic o_s_axi_rvalid, o_rx_ready, o_tx_valid, o_xfer_end, o_cpu_irq;
  wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire logic [31:0] o_s_axi_rdata;
  wire logic [7:0] o_tx_byte, i_rx_byte;
  wire logic [11:0] o_block_size_bytes;
  logic [33:0] rq[$], bq[$], tq[$];
  int error_cnt = 0, checked = 0, cyc = 0, nirq = 0, nxe = 0;
  assign {i_stop_cmd, i_block_done, i_data_cmd_start, i_data_start} = ev[6:3];
  assign {i_read_expected, i_resp_start, i_cmd_sent} = ev[2:0];
  ctb_regs u_dut (.*);
  ctb_card_model u_card (.i_sys_clk(i_sys_clk), .i_run(run), .i_rx_en(rx_en),
    .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid), .o_card_clk(i_card_clk),
    .o_rx_byte(i_rx_byte), .o_rx_valid(i_rx_valid), .o_tx_take(i_tx_take));
  always #25 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(string n, logic [33:0] s, logic [33:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    @(posedge i_sys_clk);
    bq.push_back(e);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_sys_clk);
    rq.push_back({2'b00, e});
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'b0;
  endtask
  task pulse(int b);
    @(posedge i_sys_clk);
    ev[b] <= 1'b1;
    @(posedge i_sys_clk);
    ev[b] <= 1'b0;
  endtask
  task gap();
    repeat (40) @(posedge i_sys_clk);
  endtask
  always @(posedge i_sys_clk) begin
    if (o_s_axi_bvalid && i_s_axi_bready) chk("bresp", o_s_axi_bresp, bq.pop_front());
    if (o_s_axi_rvalid && i_s_axi_rready) chk("rdata", {o_s_axi_rresp, o_s_axi_rdata}, rq.pop_front());
    if (o_tx_valid && i_tx_take) chk("tx byte", o_tx_byte, tq.pop_front());
    if (o_cpu_irq === 1'b1) nirq++;
    if (o_xfer_end === 1'b1) nxe++;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(8'(4 * i), seed | 32'h1, 2'b00);
      rd(8'(4 * i), (seed | 32'h1) & (i == 2 ? 32'hFFF : 32'hFFFF));
      if (i == 2) chk("block_size_bytes", o_block_size_bytes, seed[11:0] | 12'h1);
    end
    wr(8'h30, 32'h0, 2'b10);
    wr(8'h10, 32'hFFFF, 2'b00);
    rd(8'h10, 32'h0);
    // Response and data waits.
    wr(8'h28, 32'h10, 2'b00);
    wr(8'h00, 32'h3, 2'b00);
    wr(8'h04, 32'h2, 2'b00);
    run <= 1'b1;
    pulse(0);
    pulse(1);
    gap();
    rd(8'h24, 32'h0);
    pulse(0);
    rd(8'h24, 32'h0);
    gap();
    rd(8'h24, 32'h10);
    chk("irq", nirq, 1);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h24, 32'h10, 2'b00);
    pulse(0);
    pulse(2);
    gap();
    rd(8'h24, 32'h08);
    chk("irq", nirq, 1);
    wr(8'h28, 32'h18, 2'b00);
    wr(8'h24, 32'h08, 2'b00);
    pulse(2);
    gap();
    chk("irq", nirq, 2);
    wr(8'h24, 32'h08, 2'b00);
    wr(8'h04, 32'h0, 2'b00);
    pulse(2);
    gap();
    rd(8'h24, 32'h0);
    run <= 1'b0;
    wr(8'h0C, 32'h3, 2'b00);
    pulse(4);
    i_clk_en <= 1'b0;
    pulse(5);
    i_clk_en <= 1'b1;
    rd(8'h10, 32'h3);
    repeat (2) pulse(5);
    rd(8'h10, 32'h1);
    chk("ends", nxe, 0);
    repeat (2) pulse(5);
    rd(8'h10, 32'h0);
    chk("ends", nxe, 1);
    wr(8'h0C, 32'h0, 2'b00);
    pulse(4);
    repeat (2) pulse(5);
    chk("ends", nxe, 1);
    pulse(6);
    repeat (3) @(posedge i_sys_clk);
    chk("ends", nxe, 2);
    rx_en <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    rx_en <= 1'b0;
    rd(8'h24, 32'h100);
    rd(8'h14, 32'hA2A1);
    rd(8'h18, 32'hA4A3);
    for (int b = 0; b < 2; b++) begin
      seed = xs(seed);
      wr(8'h2C, 32'(b), 2'b00);
      wr(8'h1C, {16'h0, seed[15:0]}, 2'b00);
      for (int k = 0; k < 4; k++) tq.push_back(seed[8 * (k ^ b) +: 8]);
      wr(8'h20, {16'h0, seed[31:16]}, 2'b00);
      repeat (20) @(posedge i_sys_clk);
    end
    chk("tx left", tq.size(), 0);
    tally_and_finish();
  end
endmodule
